// >>> shared/rtca_pkg.sv
// Constants and carrier types for the timekeeper alarm and indirect access block
package rtca_pkg;

  // Special function register addresses
  localparam logic [7:0] SFR_TIMEKEEPING_CONFIG = 8'ha1;
  localparam logic [7:0] SFR_ALARM_FIELD_ENABLES = 8'ha2;
  localparam logic [7:0] SFR_TIMEKEEPER_POINTER = 8'ha3;
  localparam logic [7:0] SFR_TIMEKEEPER_DATA_WINDOW = 8'ha4;
  localparam logic [7:0] SFR_WRITE_KEY = 8'hc1;
  localparam logic [7:0] SFR_NOMINAL_TRIM = 8'hf6;
  localparam logic [7:0] SFR_THERMAL_TRIM = 8'hf7;

  // Key value that opens one protected write
  localparam logic [7:0] WRITE_KEY_VALUE = 8'hea;

  // Field positions
  localparam int ALARM_FLAG_BIT = 6;
  localparam int ACCESS_DIRECTION_BIT = 7;
  localparam int POINTER_ADDR_MSB = 4;
  localparam int NUM_ALARM_FIELDS = 5;
  localparam logic [7:0] ALARM_ENABLES_MASK = 8'h1f;
  localparam logic [7:0] POINTER_MASK = 8'h9f;

  // Indirect addresses of the counters
  localparam logic [4:0] IND_SECOND = 5'h02;
  localparam logic [4:0] IND_MINUTE = 5'h03;
  localparam logic [4:0] IND_HOUR = 5'h04;
  localparam logic [4:0] IND_WEEKDAY = 5'h05;
  localparam logic [4:0] IND_DATE = 5'h06;

  // Indirect addresses of the alarm values; enable bit n pairs with IND_SECOND_ALARM + n
  localparam logic [4:0] IND_SECOND_ALARM = 5'h0a;
  localparam logic [4:0] IND_MINUTE_ALARM = 5'h0b;
  localparam logic [4:0] IND_HOUR_ALARM = 5'h0c;
  localparam logic [4:0] IND_WEEKDAY_ALARM = 5'h0d;
  localparam logic [4:0] IND_DATE_ALARM = 5'h0e;

  // Reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [4:0] RESET_ENABLES = 5'h00;

  // Special function bus request from the processor core
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rtca_sfr_req_t;

  // Live counter values from the timekeeping counters
  typedef struct packed {
    logic [7:0] date;
    logic [7:0] weekday;
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] second;
  } rtca_counters_t;

  // Indirect write toward the timekeeping counters
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] data;
    logic wr;
  } rtca_ind_wr_t;

endpackage

// >>> core/rtca_core.sv
// Timekeeper alarm match, indirect pointer/data access and trim holding registers
//
// Overview of operation
// - Date alarm compared with date counter when enabled
// - Weekday alarm compared with weekday counter when enabled
// - Hour alarm compared with hour counter when enabled
// - Minute alarm compared with minute counter when enabled
// - Second alarm compared with second counter when enabled
// - Flag sets only when all enabled fields match
// - Flag with interrupt enable raises clock interrupt
// - Direction zero copies selected register into window
// - Direction one writes window into selected register
// - Key 0xEA just before window write permits writing
// - Pointer bits 4:0 select target; 6:5 reserved
// - Eight-bit data window, reset to zero
// - Nominal trim register holds value, drives clock
// - Thermal trim register holds temperature compensation
// - Both trim registers clear on every reset
// - Alarm flag holds until software clears it
module rtca_core
  import rtca_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  // Special function bus
  input wire rtca_sfr_req_t SFR_REQ_I,
  output logic [7:0] SFR_RDATA_O,
  // Timekeeping counters
  input wire rtca_counters_t COUNTERS_I,
  input wire logic [7:0] IND_RDATA_I,
  output logic [4:0] IND_RADDR_O,
  output rtca_ind_wr_t IND_WR_O,
  // Thermal trim loading from the calibration logic
  input wire logic THERMAL_TRIM_LOAD_I,
  input wire logic [7:0] THERMAL_TRIM_I,
  // Interrupt
  input wire logic CLOCK_IRQ_ENABLE_I,
  output logic CLOCK_IRQ_O,
  // Trim values applied to the clock
  output logic [7:0] NOMINAL_TRIM_O,
  output logic [7:0] THERMAL_TRIM_O
);

  logic [4:0] alarm_field_enables_r;
  logic [7:0] alarm_value_r [NUM_ALARM_FIELDS];
  logic [7:0] counter_value [NUM_ALARM_FIELDS];
  logic [NUM_ALARM_FIELDS-1:0] field_match;
  logic [NUM_ALARM_FIELDS-1:0] field_ok;
  logic match_rise;
  logic clear_flag;
  logic all_match;
  logic all_match_r;
  logic alarm_match_flag_r;

  logic access_direction_r;
  logic [4:0] pointer_addr_r;
  logic [7:0] timekeeper_data_window_r;
  logic key_armed_r;
  logic read_pending_r;
  logic alarm_in_range;
  logic [7:0] window_fetch;
  logic ind_wr_pulse_r;
  logic [4:0] ind_wr_addr_r;
  logic [7:0] ind_wr_data_r;

  logic [7:0] nominal_trim_r;
  logic [7:0] thermal_trim_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  logic wr_config;
  logic wr_enables;
  logic wr_pointer;
  logic wr_window;
  logic wr_key;
  logic wr_nominal;
  logic protected_write;
  logic [4:0] alarm_index;

  // Write decode; addresses are distinct, so at most one strobe is high
  always_comb begin
    wr_config = 1'b0;
    wr_enables = 1'b0;
    wr_pointer = 1'b0;
    wr_window = 1'b0;
    wr_key = 1'b0;
    wr_nominal = 1'b0;
    if (SFR_REQ_I.wr) begin
      unique case (SFR_REQ_I.addr)
        SFR_TIMEKEEPING_CONFIG: begin
          wr_config = 1'b1;
        end
        SFR_ALARM_FIELD_ENABLES: begin
          wr_enables = 1'b1;
        end
        SFR_TIMEKEEPER_POINTER: begin
          wr_pointer = 1'b1;
        end
        SFR_TIMEKEEPER_DATA_WINDOW: begin
          wr_window = 1'b1;
        end
        SFR_WRITE_KEY: begin
          wr_key = 1'b1;
        end
        SFR_NOMINAL_TRIM: begin
          wr_nominal = 1'b1;
        end
        // Thermal trim is read only; unmapped addresses ignore writes
        default: begin
        end
      endcase
    end
  end

  // Counter values in the same order as the enable bits
  assign counter_value[0] = COUNTERS_I.second;
  assign counter_value[1] = COUNTERS_I.minute;
  assign counter_value[2] = COUNTERS_I.hour;
  assign counter_value[3] = COUNTERS_I.weekday;
  assign counter_value[4] = COUNTERS_I.date;

  // A disabled field always counts as matching
  genvar g;
  generate
    for (g = 0; g < NUM_ALARM_FIELDS; g++) begin : g_field
      assign field_match[g] = (alarm_value_r[g] == counter_value[g]);
      assign field_ok[g] = !alarm_field_enables_r[g] || field_match[g];
    end
  endgenerate

  // With no field enabled the alarm stays silent rather than firing forever
  assign all_match = (&field_ok) && (|alarm_field_enables_r);

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      alarm_field_enables_r <= RESET_ENABLES;
    end else if (wr_enables) begin
      alarm_field_enables_r <= SFR_REQ_I.wdata[NUM_ALARM_FIELDS-1:0];
    end
  end

  // Field checks per enable bit: 0 second, 1 minute, 2 hour, 3 weekday, 4 date
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      all_match_r <= 1'b0;
    end else begin
      all_match_r <= all_match;
    end
  end

  assign match_rise = all_match && !all_match_r;

  // Writing a one to the flag position leaves the flag alone
  assign clear_flag = wr_config && !SFR_REQ_I.wdata[ALARM_FLAG_BIT];

  // Set on the rising edge of the match, so a clear sticks while the time
  // still matches; a set in the same cycle as a clear wins
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      alarm_match_flag_r <= 1'b0;
    end else if (match_rise) begin
      alarm_match_flag_r <= 1'b1;
    end else if (clear_flag) begin
      alarm_match_flag_r <= 1'b0;
    end
  end

  assign CLOCK_IRQ_O = alarm_match_flag_r && CLOCK_IRQ_ENABLE_I;

  // Direction bit of the pointer register
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      access_direction_r <= 1'b0;
    end else if (wr_pointer) begin
      access_direction_r <= SFR_REQ_I.wdata[ACCESS_DIRECTION_BIT];
    end
  end

  // Address field of the pointer; reserved bits 6:5 are not stored
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      pointer_addr_r <= 5'h00;
    end else if (wr_pointer) begin
      pointer_addr_r <= SFR_REQ_I.wdata[POINTER_ADDR_MSB:0];
    end
  end

  // The key must be the write directly before the window write; any other
  // bus write in between, or the protected write itself, spends it
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      key_armed_r <= 1'b0;
    end else if (wr_key) begin
      key_armed_r <= (SFR_REQ_I.wdata == WRITE_KEY_VALUE);
    end else if (SFR_REQ_I.wr) begin
      key_armed_r <= 1'b0;
    end
  end

  assign protected_write = wr_window && access_direction_r && key_armed_r;

  // A pointer write in read direction schedules one fetch in the next cycle
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      read_pending_r <= 1'b0;
    end else begin
      read_pending_r <= wr_pointer && !SFR_REQ_I.wdata[ACCESS_DIRECTION_BIT];
    end
  end

  assign alarm_index = pointer_addr_r - IND_SECOND_ALARM;
  assign alarm_in_range = (pointer_addr_r >= IND_SECOND_ALARM) &&
                          (pointer_addr_r <= IND_DATE_ALARM);

  // Alarm values answer locally so a read never waits on the counter block
  always_comb begin
    window_fetch = IND_RDATA_I;
    if (alarm_in_range) begin
      window_fetch = alarm_value_r[alarm_index[2:0]];
    end
  end

  // Alarm values live here; other addresses come from the counter block
  always_comb begin
    IND_RADDR_O = pointer_addr_r;
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      timekeeper_data_window_r <= RESET_BYTE;
    end else if (wr_window) begin
      timekeeper_data_window_r <= SFR_REQ_I.wdata;
    end else if (read_pending_r) begin
      timekeeper_data_window_r <= window_fetch;
    end
  end

  // Alarm value registers take protected writes at their indirect address
  generate
    for (g = 0; g < NUM_ALARM_FIELDS; g++) begin : g_alarm
      always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
          alarm_value_r[g] <= RESET_BYTE;
        end else if (protected_write &&
                     pointer_addr_r == IND_SECOND_ALARM + 5'(g)) begin
          alarm_value_r[g] <= SFR_REQ_I.wdata;
        end
      end
    end
  endgenerate

  // Write strobe to the counters, one cycle after the window write
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      ind_wr_pulse_r <= 1'b0;
    end else begin
      ind_wr_pulse_r <= protected_write;
    end
  end

  // Address and data hold until the next protected write
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      ind_wr_addr_r <= 5'h00;
      ind_wr_data_r <= RESET_BYTE;
    end else if (protected_write) begin
      ind_wr_addr_r <= pointer_addr_r;
      ind_wr_data_r <= SFR_REQ_I.wdata;
    end
  end

  assign IND_WR_O = '{addr: ind_wr_addr_r, data: ind_wr_data_r, wr: ind_wr_pulse_r};

  // Trims: the system reset merges watchdog, pin and power-on sources
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      nominal_trim_r <= RESET_BYTE;
    end else if (wr_nominal) begin
      nominal_trim_r <= SFR_REQ_I.wdata;
    end
  end

  // Read only to software; loaded by the calibration logic
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      thermal_trim_r <= RESET_BYTE;
    end else if (THERMAL_TRIM_LOAD_I) begin
      thermal_trim_r <= THERMAL_TRIM_I;
    end
  end

  assign NOMINAL_TRIM_O = nominal_trim_r;
  assign THERMAL_TRIM_O = thermal_trim_r;

  // Read mux; unmapped addresses and the key register read as zero
  always_comb begin
    rdata_nxt = RESET_BYTE;
    unique case (SFR_REQ_I.addr)
      // Interval timer bits live elsewhere and read as zero here
      SFR_TIMEKEEPING_CONFIG: begin
        rdata_nxt[ALARM_FLAG_BIT] = alarm_match_flag_r;
      end
      SFR_ALARM_FIELD_ENABLES: begin
        rdata_nxt = {3'h0, alarm_field_enables_r};
      end
      SFR_TIMEKEEPER_POINTER: begin
        rdata_nxt = {access_direction_r, 2'h0, pointer_addr_r};
      end
      SFR_TIMEKEEPER_DATA_WINDOW: begin
        rdata_nxt = timekeeper_data_window_r;
      end
      SFR_NOMINAL_TRIM: begin
        rdata_nxt = nominal_trim_r;
      end
      SFR_THERMAL_TRIM: begin
        rdata_nxt = thermal_trim_r;
      end
      default: begin
        rdata_nxt = RESET_BYTE;
      end
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      rdata_r <= RESET_BYTE;
    end else if (SFR_REQ_I.rd) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign SFR_RDATA_O = rdata_r;

endmodule

// >>> verif/rtca_counter_model.sv
// Behavioural model of the timekeeping counter block behind the pointer port
module rtca_counter_model
  import rtca_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Pointer port from the block
  input wire logic [4:0] raddr_i,
  input wire rtca_ind_wr_t wr_i,
  output logic [7:0] rdata_o,
  output rtca_counters_t counters_o
);
  logic [7:0] mem_r [0:31];

  // Counters stay frozen so that an alarm match holds while it is examined
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 32; i++) mem_r[i] <= 8'h00;
    end else if (wr_i.wr) begin
      mem_r[wr_i.addr] <= wr_i.data;
    end
  end

  assign rdata_o = mem_r[raddr_i];
  assign counters_o = {mem_r[6], mem_r[5], mem_r[4], mem_r[3], mem_r[2]};
endmodule

// >>> verif/rtca_core_asserts.sv
// Port checks of the alarm, pointer access and trim block
module rtca_core_asserts
  import rtca_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  // Watched ports
  input wire rtca_sfr_req_t SFR_REQ_I,
  input wire logic [7:0] SFR_RDATA_O,
  input wire logic [4:0] IND_RADDR_O,
  input wire rtca_ind_wr_t IND_WR_O,
  input wire logic THERMAL_TRIM_LOAD_I,
  input wire logic [7:0] THERMAL_TRIM_I,
  input wire logic CLOCK_IRQ_ENABLE_I,
  input wire logic CLOCK_IRQ_O,
  input wire logic [7:0] NOMINAL_TRIM_O,
  input wire logic [7:0] THERMAL_TRIM_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);
  logic key_r;
  logic dir_r;
  wire logic wp = SFR_REQ_I.wr && SFR_REQ_I.addr == SFR_TIMEKEEPER_POINTER;
  wire logic ww = SFR_REQ_I.wr && SFR_REQ_I.addr == SFR_TIMEKEEPER_DATA_WINDOW;
  wire logic wn = SFR_REQ_I.wr && SFR_REQ_I.addr == SFR_NOMINAL_TRIM;
  wire logic wk = SFR_REQ_I.addr == SFR_WRITE_KEY && SFR_REQ_I.wdata == WRITE_KEY_VALUE;
  wire logic wc = SFR_REQ_I.wr && SFR_REQ_I.addr == SFR_TIMEKEEPING_CONFIG;

  // Any write spends the key, so only the next write sees it armed
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) key_r <= 1'b0;
    else if (SFR_REQ_I.wr) key_r <= wk;
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) dir_r <= 1'b0;
    else if (wp) dir_r <= SFR_REQ_I.wdata[ACCESS_DIRECTION_BIT];
  end

  a_irq_gated: assert property (!CLOCK_IRQ_ENABLE_I |-> !CLOCK_IRQ_O)
    else $error("irq without enable");
  a_flag_holds: assert property (CLOCK_IRQ_O && !(wc && !SFR_REQ_I.wdata[6])
    |=> CLOCK_IRQ_O || !CLOCK_IRQ_ENABLE_I) else $error("flag lost");
  a_ptr_load: assert property (wp |=> IND_RADDR_O == $past(SFR_REQ_I.wdata[4:0]))
    else $error("pointer not loaded");
  a_ind_write: assert property (ww && key_r && dir_r |=> IND_WR_O.wr
    && IND_WR_O.data == $past(SFR_REQ_I.wdata) && IND_WR_O.addr == IND_RADDR_O)
    else $error("indirect write missing");
  a_key_guard: assert property (IND_WR_O.wr |-> $past(ww && key_r && dir_r))
    else $error("unkeyed indirect write");
  a_nom_write: assert property (wn |=> NOMINAL_TRIM_O == $past(SFR_REQ_I.wdata))
    else $error("nominal trim not written");
  a_nom_hold: assert property (!wn |=> $stable(NOMINAL_TRIM_O))
    else $error("nominal trim changed");
  a_therm_load: assert property (THERMAL_TRIM_LOAD_I |=>
    THERMAL_TRIM_O == $past(THERMAL_TRIM_I)) else $error("thermal trim not loaded");
  a_therm_ro: assert property (!THERMAL_TRIM_LOAD_I |=> $stable(THERMAL_TRIM_O))
    else $error("thermal trim changed");
  a_rdata_hold: assert property (!SFR_REQ_I.rd |=> $stable(SFR_RDATA_O))
    else $error("read data changed");

  c_flag: cover property ($rose(CLOCK_IRQ_O));
  c_ind_wr: cover property (IND_WR_O.wr);
  c_therm: cover property (THERMAL_TRIM_LOAD_I);
endmodule

bind rtca_core rtca_core_asserts chk_u (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I),
  .SFR_REQ_I(SFR_REQ_I), .SFR_RDATA_O(SFR_RDATA_O), .IND_RADDR_O(IND_RADDR_O),
  .IND_WR_O(IND_WR_O), .THERMAL_TRIM_LOAD_I(THERMAL_TRIM_LOAD_I),
  .THERMAL_TRIM_I(THERMAL_TRIM_I), .CLOCK_IRQ_ENABLE_I(CLOCK_IRQ_ENABLE_I),
  .CLOCK_IRQ_O(CLOCK_IRQ_O), .NOMINAL_TRIM_O(NOMINAL_TRIM_O), .THERMAL_TRIM_O(THERMAL_TRIM_O));

// >>> verif/rtca_core_tb.sv
// Self-checking bench for the alarm, pointer access and trim block
module rtca_core_tb
  import rtca_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLOCK_I = 1'b0;
  logic RST_N_I = 1'b0;
  rtca_sfr_req_t req = '0;
  rtca_counters_t cnt;
  rtca_ind_wr_t iw;
  logic [4:0] ira;
  logic [7:0] ird_d, rdata, nom, therm, d;
  logic tload = 1'b0;
  logic [7:0] tval = 8'h00;
  logic irq_en = 1'b1;
  logic irq;
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;

  rtca_core dut_u (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .SFR_REQ_I(req), .SFR_RDATA_O(rdata),
    .COUNTERS_I(cnt), .IND_RDATA_I(ird_d), .IND_RADDR_O(ira), .IND_WR_O(iw),
    .THERMAL_TRIM_LOAD_I(tload), .THERMAL_TRIM_I(tval), .CLOCK_IRQ_ENABLE_I(irq_en),
    .CLOCK_IRQ_O(irq), .NOMINAL_TRIM_O(nom), .THERMAL_TRIM_O(therm));
  rtca_counter_model part_u (.clk_i(CLOCK_I), .rst_n_i(RST_N_I), .raddr_i(ira), .wr_i(iw),
    .rdata_o(ird_d), .counters_o(cnt));

  initial forever #5 CLOCK_I = ~CLOCK_I;

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // A hung handshake is cut short here
  always @(posedge CLOCK_I) begin
    cyc++;
    if (cyc > 5000) begin
      errors++;
      end_of_test();
    end
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge CLOCK_I) req = '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(negedge CLOCK_I) req.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge CLOCK_I) req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(negedge CLOCK_I) req.rd = 1'b0;
    d = rdata;
  endtask

  task automatic iwr(input logic [4:0] p, input logic [7:0] v);
    wr(SFR_TIMEKEEPER_POINTER, {3'b100, p});
    wr(SFR_WRITE_KEY, WRITE_KEY_VALUE);
    wr(SFR_TIMEKEEPER_DATA_WINDOW, v);
  endtask

  task automatic ird(input logic [4:0] p);
    wr(SFR_TIMEKEEPER_POINTER, {3'b000, p});
    rd(SFR_TIMEKEEPER_DATA_WINDOW);
  endtask

  task automatic t_reset_vals();
    logic [7:0] a [6] = '{SFR_TIMEKEEPING_CONFIG, SFR_ALARM_FIELD_ENABLES,
      SFR_TIMEKEEPER_POINTER, SFR_TIMEKEEPER_DATA_WINDOW, SFR_NOMINAL_TRIM, SFR_THERMAL_TRIM};
    foreach (a[i]) begin
      rd(a[i]);
      chk("reset value", RESET_BYTE, d);
    end
    chk("trims", 8'h00, nom | therm);
  endtask

  task automatic t_fields();
    wr(SFR_TIMEKEEPER_POINTER, 8'hff);
    rd(SFR_TIMEKEEPER_POINTER);
    chk("pointer", POINTER_MASK, d);
    wr(SFR_NOMINAL_TRIM, 8'h5a);
    rd(SFR_NOMINAL_TRIM);
    chk("nominal", 8'h5a, d);
    wr(SFR_THERMAL_TRIM, 8'ha5);
    rd(SFR_THERMAL_TRIM);
    chk("thermal read only", 8'h00, d);
    @(negedge CLOCK_I) {tload, tval} = {1'b1, 8'h3c};
    @(negedge CLOCK_I) tload = 1'b0;
    rd(SFR_THERMAL_TRIM);
    chk("thermal", 8'h3c, d);
  endtask

  task automatic t_key();
    wr(SFR_TIMEKEEPER_POINTER, 8'h82);
    wr(SFR_WRITE_KEY, 8'h55);
    wr(SFR_TIMEKEEPER_DATA_WINDOW, 8'h77);
    wr(SFR_WRITE_KEY, WRITE_KEY_VALUE);
    wr(SFR_ALARM_FIELD_ENABLES, 8'h00);
    wr(SFR_TIMEKEEPER_DATA_WINDOW, 8'h78);
    iwr(IND_SECOND, 8'h79);
    wr(SFR_TIMEKEEPER_DATA_WINDOW, 8'h7a);
    ird(IND_SECOND);
    chk("keyed write", 8'h79, d);
  endtask

  task automatic t_alarm();
    for (int k = 0; k < NUM_ALARM_FIELDS; k++) begin
      wr(SFR_ALARM_FIELD_ENABLES, 8'h00);
      iwr(5'(IND_SECOND + k), 8'h50 + 8'(k));
      iwr(5'(IND_SECOND_ALARM + k), 8'h50 + 8'(k));
      ird(5'(IND_SECOND_ALARM + k));
      chk("alarm value", 8'h50 + 8'(k), d);
      rd(SFR_TIMEKEEPING_CONFIG);
      chk("flag off", 8'h00, d);
      wr(SFR_ALARM_FIELD_ENABLES, 8'(1 << k));
      rd(SFR_TIMEKEEPING_CONFIG);
      chk("flag on", 8'h40, d);
      chk("irq", 8'h01, {7'h00, irq});
      wr(SFR_TIMEKEEPING_CONFIG, 8'h40);
      rd(SFR_TIMEKEEPING_CONFIG);
      chk("flag kept", 8'h40, d);
      wr(SFR_TIMEKEEPING_CONFIG, 8'h00);
      rd(SFR_TIMEKEEPING_CONFIG);
      chk("flag clear", 8'h00, d);
      iwr(5'(IND_SECOND_ALARM + k), 8'h00);
    end
  endtask

  task automatic t_all_fields();
    for (int k = 0; k < 4; k++) iwr(5'(IND_SECOND_ALARM + k), 8'h50 + 8'(k));
    wr(SFR_ALARM_FIELD_ENABLES, 8'h1f);
    rd(SFR_TIMEKEEPING_CONFIG);
    chk("partial match", 8'h00, d);
    irq_en = 1'b0;
    iwr(IND_DATE_ALARM, 8'h54);
    rd(SFR_TIMEKEEPING_CONFIG);
    chk("full match", 8'h40, d);
    chk("irq masked", 8'h00, {7'h00, irq});
    @(negedge CLOCK_I) irq_en = 1'b1;
    #1;
    chk("irq open", 8'h01, {7'h00, irq});
  endtask

  initial begin
    repeat (8) @(negedge CLOCK_I);
    RST_N_I = 1'b1;
    t_reset_vals();
    t_fields();
    t_key();
    t_alarm();
    t_all_fields();
    chk("trims set", 8'h66, nom ^ therm);
    @(negedge CLOCK_I) RST_N_I = 1'b0;
    repeat (2) @(negedge CLOCK_I);
    RST_N_I = 1'b1;
    t_reset_vals();
    end_of_test();
  end
endmodule
